/* rtl/mrr_pkg.sv */
// mrr_pkg: register map, status layout and carrier types of the motion report registers
// assumes: the navigation logic delivers signed per-frame deltas on the reference clock
package mrr_pkg;

   // register addresses, 7-bit serial address space
   localparam logic [6:0] ADDR_CHIP_REV  = 7'h01;
   localparam logic [6:0] ADDR_STATUS    = 7'h02;
   localparam logic [6:0] ADDR_X_DISP    = 7'h03;
   localparam logic [6:0] ADDR_Y_DISP    = 7'h04;
   localparam logic [6:0] ADDR_SURFACE   = 7'h05;
   localparam logic [6:0] ADDR_FW_REV    = 7'h1F;

   // status field positions and reserved mask
   localparam int         STAT_MOT_BIT   = 7;
   localparam int         STAT_OVF_BIT   = 4;
   localparam int         STAT_CPI_BIT   = 0;
   localparam logic [7:0] STAT_RSVD_MASK = 8'h6E;

   // reset values and limits
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [7:0] SURFACE_MAX    = 8'hA9;
   localparam logic [7:0] DISP_POS_FULL  = 8'h7F;
   localparam logic [7:0] DISP_NEG_FULL  = 8'h80;

   // 400 cpi reports the fine count divided by four
   localparam int         CPI_LOW_SHIFT  = 2;

   // serial frame: one command byte then one data byte
   localparam logic [4:0] CMD_LAST_BIT   = 5'h07;
   localparam logic [4:0] DATA_LOAD_CNT  = 5'h08;
   localparam logic [4:0] FRAME_BITS     = 5'h10;
   localparam int         CMD_WRITE_BIT  = 6;

   typedef struct packed {
      logic       valid;
      logic [7:0] dx;
      logic [7:0] dy;
   } mrr_nav_t;

endpackage

/* rtl/mrr_top.sv */
// mrr_top: read side of the motion report registers behind the four-wire serial port
// assumes: host clocks the port in mode 3 and pauses between command and data byte;
// navigation, resolution and feature inputs come from logic on I_REF_CLK
//
// Function
// - read-only chip revision register
// - firmware revision kept in separate register
// - status bit 7 flags pending motion
// - status bit 4 flags accumulator overflow
// - status bit 0 shows active resolution
// - status read freezes both displacement values
// - second status read discards unread frozen data
// - wide accumulators; overflow sets overflow flag
// - overflow clears after read, below full scale
// - after overflow reads return full scale
// - X register: signed count since report
// - Y register: signed count since report
// - reading displacement register clears it
// - surface register is feature count over four
// - surface register never above 169
// - all registers reached over serial port
`timescale 1ns/1ps
`default_nettype none

module mrr_top #(
   parameter int         ACC_W    = 16,
   parameter logic [7:0] CHIP_REV = 8'h2C   // arbitrary value
) (
   input  wire logic            I_REF_CLK,
   input  wire logic            I_RST_N,
   input  wire logic            I_SCLK,
   input  wire logic            I_NCS_N,
   input  wire logic            I_MOSI,
   output logic                 O_MISO,
   output logic                 O_MISO_OE,
   input  wire mrr_pkg::mrr_nav_t I_NAV,
   input  wire logic            I_CPI_SEL,
   input  wire logic            I_POWER_DOWN,
   input  wire logic [9:0]      I_FEATURE_CNT,
   input  wire logic            I_FW_LOAD,
   input  wire logic [7:0]      I_FW_REV
);

   localparam logic [ACC_W-1:0]   ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
   localparam logic [ACC_W-1:0]   ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};
   localparam logic [ACC_W+1:0]   SUM_MAX = {2'b00, ACC_MAX};
   localparam logic [ACC_W+1:0]   SUM_MIN = {2'b11, ACC_MIN};

   logic                link_rst_n;
   logic [4:0]          bit_cnt_r;
   logic [7:0]          cmd_sh_r;
   logic [7:0]          tx_r;
   logic                req_tog_r;
   logic [6:0]          req_addr_r;
   logic [2:0]          req_sync_r;
   logic                req_pulse;
   logic                status_rd;
   logic                x_rd;
   logic                y_rd;
   logic [7:0]          rd_data_r;
   logic [ACC_W-1:0]    acc_x_r;
   logic [ACC_W-1:0]    acc_y_r;
   logic [7:0]          frozen_x_r;
   logic [7:0]          frozen_y_r;
   logic                ovf_r;
   logic [7:0]          fw_rev_r;
   logic [7:0]          rep_x;
   logic [7:0]          rep_y;
   logic [ACC_W:0]      step_x;
   logic [ACC_W:0]      step_y;
   logic                motion_pending;
   logic                ovf_clr;
   logic [7:0]          status_now;
   logic [7:0]          surface;

   // link side: frame logic is cleared whenever chip select is high
   assign link_rst_n = I_RST_N & ~I_NCS_N;

   always_ff @(posedge I_SCLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt_r <= 5'h00;
         cmd_sh_r  <= 8'h00;
      end else begin
         if (bit_cnt_r != mrr_pkg::FRAME_BITS) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
         cmd_sh_r <= {cmd_sh_r[6:0], I_MOSI};
      end
   end

   // request toggle survives chip select so no false event is made
   always_ff @(posedge I_SCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         req_tog_r  <= 1'b0;
         req_addr_r <= 7'h00;
      end else if (bit_cnt_r == mrr_pkg::CMD_LAST_BIT && !cmd_sh_r[mrr_pkg::CMD_WRITE_BIT]) begin
         req_tog_r  <= ~req_tog_r;
         req_addr_r <= {cmd_sh_r[5:0], I_MOSI};
      end
   end

   // read data shifts out msb first on falling edges; rd_data_r is settled by the host pause
   always_ff @(negedge I_SCLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_r <= 8'h00;
      end else if (bit_cnt_r == mrr_pkg::DATA_LOAD_CNT) begin
         tx_r <= rd_data_r;
      end else begin
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end

   assign O_MISO    = tx_r[7];
   assign O_MISO_OE = ~I_NCS_N;   // pin released outside frames

   // toggle crossing into the reference domain; edge taken past the second stage
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         req_sync_r <= 3'b000;
      end else begin
         req_sync_r <= {req_sync_r[1:0], req_tog_r};
      end
   end

   assign req_pulse = req_sync_r[2] ^ req_sync_r[1];
   assign status_rd = req_pulse && (req_addr_r == mrr_pkg::ADDR_STATUS);
   assign x_rd      = req_pulse && (req_addr_r == mrr_pkg::ADDR_X_DISP);
   assign y_rd      = req_pulse && (req_addr_r == mrr_pkg::ADDR_Y_DISP);

   // scale to the selected resolution and clip to one signed byte
   function automatic logic [7:0] report(input logic [ACC_W-1:0] acc, input logic cpi_hi);
      logic signed [ACC_W-1:0] s;
      s = cpi_hi ? signed'(acc) : (signed'(acc) >>> mrr_pkg::CPI_LOW_SHIFT);
      if (s > signed'({{(ACC_W-8){1'b0}}, mrr_pkg::DISP_POS_FULL})) begin
         return mrr_pkg::DISP_POS_FULL;
      end else if (s < signed'({{(ACC_W-8){1'b1}}, mrr_pkg::DISP_NEG_FULL})) begin
         return mrr_pkg::DISP_NEG_FULL;
      end else begin
         return s[7:0];
      end
   endfunction

   // add new motion, remove the reported part; msb of result flags saturation
   function automatic logic [ACC_W:0] acc_step(input logic [ACC_W-1:0] acc, input logic [7:0] d,
                                               input logic [7:0] rep, input logic take, input logic cpi_hi);
      logic signed [ACC_W+1:0] s;
      logic        [ACC_W+1:0] t;
      s = signed'({{2{acc[ACC_W-1]}}, acc}) + signed'({{(ACC_W-6){d[7]}}, d});
      t = {{(ACC_W-6){rep[7]}}, rep};
      if (!cpi_hi) begin
         t = t << mrr_pkg::CPI_LOW_SHIFT;
      end
      if (take) begin
         s = s - signed'(t);
      end
      if (s > signed'(SUM_MAX)) begin
         return {1'b1, ACC_MAX};
      end else if (s < signed'(SUM_MIN)) begin
         return {1'b1, ACC_MIN};
      end else begin
         return {1'b0, s[ACC_W-1:0]};
      end
   endfunction

   // reported values in the active resolution
   assign rep_x  = report(acc_x_r, I_CPI_SEL);
   assign rep_y  = report(acc_y_r, I_CPI_SEL);
   assign step_x = acc_step(acc_x_r, I_NAV.valid ? I_NAV.dx : 8'h00, rep_x, status_rd, I_CPI_SEL);
   assign step_y = acc_step(acc_y_r, I_NAV.valid ? I_NAV.dy : 8'h00, rep_y, status_rd, I_CPI_SEL);

   // pending only while a nonzero report remains
   assign motion_pending = (rep_x != 8'h00) || (rep_y != 8'h00);

   // accumulators saturate at full scale, so drained reads clip
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         acc_x_r <= '0;
         acc_y_r <= '0;
      end else if (I_POWER_DOWN) begin
         acc_x_r <= '0;
         acc_y_r <= '0;
      end else begin
         acc_x_r <= step_x[ACC_W-1:0];
         acc_y_r <= step_y[ACC_W-1:0];
      end
   end

   // freeze on status read, clear on displacement read
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         frozen_x_r <= mrr_pkg::REG_RESET;
         frozen_y_r <= mrr_pkg::REG_RESET;
      end else if (I_POWER_DOWN) begin
         frozen_x_r <= mrr_pkg::REG_RESET;
         frozen_y_r <= mrr_pkg::REG_RESET;
      end else if (status_rd) begin
         frozen_x_r <= rep_x;   // unread older values are lost here
         frozen_y_r <= rep_y;
      end else begin
         if (x_rd) begin
            frozen_x_r <= mrr_pkg::REG_RESET;
         end
         if (y_rd) begin
            frozen_y_r <= mrr_pkg::REG_RESET;
         end
      end
   end

   // clear needs a displacement read with both accumulators off full scale
   assign ovf_clr = (x_rd || y_rd) && (step_x[ACC_W-1:0] != ACC_MAX) && (step_x[ACC_W-1:0] != ACC_MIN)
                    && (step_y[ACC_W-1:0] != ACC_MAX) && (step_y[ACC_W-1:0] != ACC_MIN);

   // overflow flag; a new overflow beats the clear
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ovf_r <= 1'b0;
      end else if (I_POWER_DOWN) begin
         ovf_r <= 1'b0;
      end else if (step_x[ACC_W] || step_y[ACC_W]) begin
         ovf_r <= 1'b1;
      end else if (ovf_clr) begin
         ovf_r <= 1'b0;
      end
   end

   // firmware revision held apart from the chip revision
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         fw_rev_r <= mrr_pkg::REG_RESET;
      end else if (I_FW_LOAD) begin
         fw_rev_r <= I_FW_REV;
      end
   end

   always_comb begin
      status_now                        = 8'h00;
      status_now[mrr_pkg::STAT_MOT_BIT] = motion_pending;
      status_now[mrr_pkg::STAT_OVF_BIT] = ovf_r;
      status_now[mrr_pkg::STAT_CPI_BIT] = I_CPI_SEL;
   end

   // upper bits of the feature count, capped
   assign surface = (I_FEATURE_CNT[9:2] > mrr_pkg::SURFACE_MAX) ? mrr_pkg::SURFACE_MAX : I_FEATURE_CNT[9:2];

   // read answer captured once per request; unmapped reads return zero
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rd_data_r <= mrr_pkg::REG_RESET;
      end else if (req_pulse) begin
         case (req_addr_r)
            mrr_pkg::ADDR_CHIP_REV: rd_data_r <= CHIP_REV;
            mrr_pkg::ADDR_STATUS:   rd_data_r <= status_now;
            mrr_pkg::ADDR_X_DISP:   rd_data_r <= frozen_x_r;
            mrr_pkg::ADDR_Y_DISP:   rd_data_r <= frozen_y_r;
            mrr_pkg::ADDR_SURFACE:  rd_data_r <= surface;
            mrr_pkg::ADDR_FW_REV:   rd_data_r <= fw_rev_r;
            default:                rd_data_r <= mrr_pkg::REG_RESET;
         endcase
      end
   end

   sequence s_status_rd;
      status_rd && !I_POWER_DOWN;
   endsequence

   sequence s_x_drain;
      x_rd && !status_rd && !I_POWER_DOWN;
   endsequence

   chk_rev_value: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      req_pulse && req_addr_r == mrr_pkg::ADDR_CHIP_REV |=> rd_data_r == CHIP_REV)
      else $error("chip revision read wrong");

   chk_status_mot: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      s_status_rd |=> rd_data_r[mrr_pkg::STAT_MOT_BIT] == $past(motion_pending)
                      && rd_data_r[mrr_pkg::STAT_CPI_BIT] == $past(I_CPI_SEL))
      else $error("status motion or resolution bit wrong");

   chk_status_rsvd: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      s_status_rd |=> (rd_data_r & mrr_pkg::STAT_RSVD_MASK) == 8'h00)
      else $error("reserved status bits not zero");

   chk_freeze_x: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      s_status_rd |=> frozen_x_r == $past(rep_x) && frozen_y_r == $past(rep_y))
      else $error("displacement not frozen on status read");

   chk_x_clears: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      s_x_drain |=> frozen_x_r == mrr_pkg::REG_RESET)
      else $error("X register not cleared by read");

   chk_x_answer: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      x_rd |=> rd_data_r == $past(frozen_x_r))
      else $error("X read returned wrong value");

   chk_ovf_sets: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (step_x[ACC_W] || step_y[ACC_W]) && !I_POWER_DOWN |=> ovf_r)
      else $error("overflow flag not set");

   chk_ovf_holds: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      ovf_r && !x_rd && !y_rd && !I_POWER_DOWN |=> ovf_r)
      else $error("overflow flag cleared without displacement read");

   chk_full_scale: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      s_status_rd ##0 (acc_x_r == ACC_MAX) |=> frozen_x_r == mrr_pkg::DISP_POS_FULL)
      else $error("saturated accumulator not reported full scale");

   chk_surface_cap: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      req_pulse && req_addr_r == mrr_pkg::ADDR_SURFACE |=> rd_data_r <= mrr_pkg::SURFACE_MAX)
      else $error("surface register above limit");

endmodule

`default_nettype wire

/* tb/mrr_host_model.sv */
// mrr_host_model: microcontroller side of the four-wire serial port, reads one register a frame
// assumes: port mode 3, the device answers on i_miso after the 100 ns pause
`timescale 1ns/1ps
`default_nettype none

module mrr_host_model #(
   parameter int HALF_NS = 16
) (
   input  wire logic i_miso,
   output logic      o_sclk,
   output logic      o_ncs_n,
   output logic      o_mosi
);
   // serial clock idles high and stands still between frames
   initial begin
      o_sclk  = 1'b1;
      o_ncs_n = 1'b1;
      o_mosi  = 1'b0;
   end

   task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
      logic [7:0] cmd;
      cmd = {1'b0, addr};
      #3;                         // odd offset keeps edges off the core clock when the read starts on a clock edge
      o_ncs_n = 1'b0;
      #(HALF_NS);
      for (int i = 7; i >= 0; i--) begin
         o_sclk = 1'b0;
         o_mosi = cmd[i];
         #(HALF_NS);
         o_sclk = 1'b1;
         #(HALF_NS);
      end
      o_mosi = ~cmd[0];           // line driven to the inverse of the last command bit so no stale bit shows
      #100;                       // pause the device needs before data
      for (int i = 7; i >= 0; i--) begin
         o_sclk = 1'b0;
         #(HALF_NS);
         o_sclk = 1'b1;
         data[i] = i_miso;
         #(HALF_NS);
      end
      o_ncs_n = 1'b1;
      #48;
   endtask
endmodule

`default_nettype wire

/* tb/tb_top.sv */
// tb_top: self-checking bench of the motion report registers
// assumes: host model reaches registers only over the serial port; core inputs on I_REF_CLK
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam logic [7:0] CHIP_REV = 8'h5A;  // arbitrary value
   localparam int         ACC_W    = 10;     // small so saturation comes quickly

   logic              ref_clk, rst_n, sclk, ncs_n, mosi, miso, miso_oe, miso_line;
   logic              cpi_sel, power_down, fw_load;
   logic [9:0]        feature_cnt;
   logic [7:0]        fw_rev;
   mrr_pkg::mrr_nav_t nav;
   int                err_count, n_compared;

   mrr_top #(.ACC_W(ACC_W), .CHIP_REV(CHIP_REV)) i_dut (
      .I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_NCS_N(ncs_n), .I_MOSI(mosi),
      .O_MISO(miso), .O_MISO_OE(miso_oe), .I_NAV(nav), .I_CPI_SEL(cpi_sel),
      .I_POWER_DOWN(power_down), .I_FEATURE_CNT(feature_cnt), .I_FW_LOAD(fw_load), .I_FW_REV(fw_rev)
   );

   // released line floats to its pull-up, so a missing output enable shows as ones
   assign miso_line = miso_oe ? miso : 1'b1;

   mrr_host_model i_host (.i_miso(miso_line), .o_sclk(sclk), .o_ncs_n(ncs_n), .o_mosi(mosi));

   // core clock, 8 ns
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic finish_test();
      $display("compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // read one register and compare with the expected byte
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      i_host.read_reg(a, d);
      n_compared++;
      if (d !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, d, exp);
      end
      n_compared++;
      if (miso_oe !== 1'b0) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s data pin still enabled after frame", $time, what);
      end
   endtask

   // one navigation frame of fine counts
   task automatic move(input logic [7:0] x, input logic [7:0] y);
      @(posedge ref_clk);
      nav <= '{valid: 1'b1, dx: x, dy: y};
      @(posedge ref_clk);
      nav.valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic set_cpi(input logic v);
      @(posedge ref_clk);
      cpi_sel <= v;
   endtask

   task automatic t_reset();
      rd_chk(mrr_pkg::ADDR_CHIP_REV, CHIP_REV, "chip revision");
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h00, "idle status");
      rd_chk(7'h06, 8'h00, "unmapped address");
      rd_chk(mrr_pkg::ADDR_X_DISP, 8'h00, "idle x");
   endtask

   task automatic t_motion();
      set_cpi(1'b1);
      move(8'h05, 8'hFD);
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h81, "status after move");
      rd_chk(mrr_pkg::ADDR_X_DISP, 8'h05, "x count");
      rd_chk(mrr_pkg::ADDR_Y_DISP, 8'hFD, "y count");
      rd_chk(mrr_pkg::ADDR_X_DISP, 8'h00, "x after read");
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h01, "status drained");
   endtask

   task automatic t_cpi_low();
      set_cpi(1'b0);
      move(8'h0C, 8'hF8);
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h80, "status 400 cpi");
      rd_chk(mrr_pkg::ADDR_X_DISP, 8'h03, "x scaled");
      rd_chk(mrr_pkg::ADDR_Y_DISP, 8'hFE, "y scaled");
   endtask

   task automatic t_discard();
      set_cpi(1'b1);
      move(8'h02, 8'h00);
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h81, "first status");
      move(8'h03, 8'h00);
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h81, "second status");
      rd_chk(mrr_pkg::ADDR_X_DISP, 8'h03, "old x lost");
      rd_chk(mrr_pkg::ADDR_Y_DISP, 8'h00, "y empty");
   endtask

   // five frames of +127 saturate a 10-bit accumulator at 511
   task automatic t_overflow();
      repeat (5) move(8'h7F, 8'h00);
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h91, "overflow status");
      move(8'h7F, 8'h00);                                     // refills exactly to full scale
      rd_chk(mrr_pkg::ADDR_X_DISP, 8'h7F, "x at full scale");
      rd_chk(mrr_pkg::ADDR_Y_DISP, 8'h00, "y while full");
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h91, "overflow kept");
      rd_chk(mrr_pkg::ADDR_X_DISP, 8'h7F, "x full scale");
      rd_chk(mrr_pkg::ADDR_Y_DISP, 8'h00, "y quiet");
      for (int i = 0; i < 4; i++) begin
         rd_chk(mrr_pkg::ADDR_STATUS, 8'h81, "drain status");
         rd_chk(mrr_pkg::ADDR_X_DISP, (i < 3) ? 8'h7F : 8'h03, "drain x");
         rd_chk(mrr_pkg::ADDR_Y_DISP, 8'h00, "drain y");
      end
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h01, "drained");
   endtask

   task automatic t_surface();
      @(posedge ref_clk);
      feature_cnt <= 10'h0C8;
      rd_chk(mrr_pkg::ADDR_SURFACE, 8'h32, "feature quarter");
      @(posedge ref_clk);
      feature_cnt <= 10'h3FF;
      rd_chk(mrr_pkg::ADDR_SURFACE, 8'hA9, "feature limit");
   endtask

   task automatic t_fw_pd();
      @(posedge ref_clk);
      fw_rev  <= 8'h3C;
      fw_load <= 1'b1;
      @(posedge ref_clk);
      fw_load <= 1'b0;
      rd_chk(mrr_pkg::ADDR_FW_REV, 8'h3C, "firmware revision");
      rd_chk(mrr_pkg::ADDR_CHIP_REV, CHIP_REV, "chip kept");
      move(8'h10, 8'h10);
      @(posedge ref_clk);
      power_down <= 1'b1;
      repeat (4) @(posedge ref_clk);
      power_down <= 1'b0;
      rd_chk(mrr_pkg::ADDR_STATUS, 8'h01, "status after sleep");
      rd_chk(mrr_pkg::ADDR_X_DISP, 8'h00, "x after sleep");
   endtask

   // hang guard, far beyond the roughly 40 frames of the run
   initial begin
      #200000;
      err_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      finish_test();
   end

   // reset for 16 cycles, then the scenarios
   initial begin
      rst_n       = 1'b0;
      nav         = '0;
      cpi_sel     = 1'b0;
      power_down  = 1'b0;
      fw_load     = 1'b0;
      fw_rev      = 8'h00;
      feature_cnt = 10'h000;
      err_count   = 0;
      n_compared  = 0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_reset();
      t_motion();
      t_cpi_low();
      t_discard();
      t_overflow();
      t_surface();
      t_fw_pd();
      finish_test();
   end
endmodule

`default_nettype wire
